// >>> include/wake_proxy_pkg.sv
// constants for the wake and proxy filter register block
package wake_proxy_pkg;
  // register byte addresses
  localparam logic [15:0] WAKE_FILTER_ENABLE_ADDR = 16'h5808;
  localparam logic [15:0] WAKE_MATCH_STATUS_ADDR  = 16'h5810;
  localparam logic [15:0] WAKE_PACKET_LENGTH_ADDR = 16'h5900;
  localparam logic [15:0] WAKE_PACKET_MEMORY_ADDR = 16'h5a00;
  localparam logic [15:0] PROXY_FILTER_ENABLE_ADDR = 16'h5f60;
  localparam logic [15:0] PROXY_MATCH_STATUS_ADDR = 16'h5f64;
  localparam logic [15:0] WAKE_PACKET_MEMORY_SPAN = 16'h0080;
  // reset values
  localparam logic [31:0] ENABLE_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET_VALUE = 32'h0000_0000;
  // writable bit masks (reserved bits read as zero)
  localparam logic [31:0] WAKE_ENABLE_MASK   = 32'h8fff_ceff;  // bits 0-7, 9-11, 14-27, 31
  localparam logic [31:0] PROXY_ENABLE_MASK  = 32'h00ff_0efd;
  localparam logic [31:0] WAKE_STATUS_MASK   = 32'h80ff_0eff;
  localparam logic [31:0] PROXY_STATUS_MASK  = 32'h00ff_0efc;
  // field positions in the enable and status words; offload D0 and flex queuing are enable bits only
  localparam int LINK_CHANGE_BIT    = 0;
  localparam int DIRECTED_UCAST_BIT = 2;
  localparam int GROUP_HASH_BIT     = 3;
  localparam int OFFLOAD_D0_BIT     = 0;
  localparam int FLEX_QUEUING_BIT   = 14;
  localparam int FLEX_LOW_BIT       = 16;
  localparam int FIRMWARE_WAKE_BIT  = 31;
  localparam int FLEX_COUNT         = 8;
  // wake packet capture
  localparam int CAPTURE_WORDS      = 32;
  localparam logic [11:0] LENGTH_SATURATION = 12'h7ff;
endpackage

// >>> logic/wake_proxy_filter_regs.sv
// wake and proxy filter registers with first wake packet capture
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
// Summary of operation
// R1: wake enable bits 0-7 and 9-11 arm sources
// R2: bits 16-23 arm flex filters, actions
// R3: unicast promiscuous plus directed enable wakes all
// R4: flex queuing bit steers queues in D0
// R5: firmware reset wakes when bit 31 set
// R6: ARP target match needs IPv4 table hit
// R7: solicitation target compares IPv6 table; NS broad
// R8: status sets matched bits; write one clears
// R9: status survives PCIe reset; power-good clears
// R10: wake status frozen after first packet
// R11: proxy status keeps accumulating matches
// R12: directed unicast status needs unicast promiscuous, not address hit
// R13: multicast status on hash hit or promiscuous
// R14: flex status only when flex queuing off
// R15: status bit 31 marks firmware reset wake
// R16: length field holds first wake length
// R17: length saturates at 2047 with jumbo
// R18: 32 words capture first 128 bytes
// R19: offload D0 bit allows offload in D0 as well as D3
// R20: offload needs host and management enables
// R21: proxy enable mirrors wake criteria
// R22: promiscuous unicast proxy forwards all unicast
// R23: host proxy enable allows D3 proxying
// R24: commit only after good frame check
module wake_proxy_filter_regs #(
  parameter int CAPTURE_DEPTH = wake_proxy_pkg::CAPTURE_WORDS
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,              // controller reset, clears enables, keeps status
  input  wire logic        pcie_reset_input_n_in, // does not touch status
  input  wire logic        aux_power_good_in,     // low clears status
  // avalon-mm slave
  input  wire logic [15:0] avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic      [1:0]  avs_response_out,
  // receive side decisions, one per packet
  input  wire logic        rx_data_valid_in,      // one 32-bit packet word
  input  wire logic [31:0] rx_data_in,
  input  wire logic        rx_end_in,             // packet finished
  input  wire logic        rx_crc_good_in,
  input  wire logic [13:0] rx_length_in,
  input  wire logic        jumbo_enable_in,
  input  wire logic        unicast_promiscuous_in,
  input  wire logic        multicast_promiscuous_in,
  input  wire logic        is_unicast_in,
  input  wire logic        address_hit_in,        // one of 32 receive addresses
  input  wire logic        is_multicast_in,
  input  wire logic        hash_hit_in,           // multicast hash table bit
  input  wire logic        is_broadcast_in,
  input  wire logic        wol_pattern_in,
  input  wire logic        arp_request_in,
  input  wire logic        ipv4_table_hit_in,
  input  wire logic        ipv4_directed_in,
  input  wire logic        ipv6_directed_in,
  input  wire logic        icmpv6_in,
  input  wire logic        ipv6_table_hit_in,     // bytes 9..24 of icmpv6 header
  input  wire logic [7:0]  flex_match_in,
  input  wire logic        link_change_in,
  input  wire logic        firmware_reset_in,
  input  wire logic        host_proxy_enable_in,
  input  wire logic        management_proxy_enable_in,
  input  wire logic        device_in_d3_in,
  output logic             wake_event_out,        // one-cycle wake request
  output logic             proxy_forward_out,     // packet goes to management
  output logic      [7:0]  flex_queue_steer_out,  // flex hits for D0 queuing
  output logic             proxy_active_out
);

  // elaboration check: the capture window is exactly 128 bytes
  if (CAPTURE_DEPTH != wake_proxy_pkg::CAPTURE_WORDS) begin : g_depth_check
    $error("capture depth must be 32 words");
  end

  // registers
  logic [31:0] wake_filter_enable_reg;
  logic [31:0] proxy_filter_enable_reg;
  logic [31:0] wake_match_status_reg;
  logic [31:0] proxy_match_status_reg;
  logic [11:0] wake_packet_length_reg;            // no reset
  logic [31:0] capture_mem_reg [CAPTURE_DEPTH];   // no reset
  logic [5:0]  capture_index_reg;                 // words captured from current packet
  logic [31:0] readdata_reg;
  logic [1:0]  response_reg;
  logic        ack_reg;
  logic        wake_event_reg;
  logic        proxy_forward_reg;
  logic [7:0]  flex_steer_reg;
  logic        proxy_active_reg;
  logic        pg_meta_reg, pg_sync_reg, pg_last_reg; // power-good synchroniser
  logic        fw_meta_reg, fw_sync_reg, fw_last_reg; // firmware reset synchroniser
  logic        pcie_meta_reg, pcie_sync_reg;           // observed only
  logic        fw_prev_reg;                            // agreed firmware level of the last cycle

  // bus decode
  wire         access       = (avs_read_in | avs_write_in) & ~ack_reg;
  wire         hit_wfe      = avs_address_in == wake_proxy_pkg::WAKE_FILTER_ENABLE_ADDR;
  wire         hit_wms      = avs_address_in == wake_proxy_pkg::WAKE_MATCH_STATUS_ADDR;
  wire         hit_wpl      = avs_address_in == wake_proxy_pkg::WAKE_PACKET_LENGTH_ADDR;
  wire         hit_pfe      = avs_address_in == wake_proxy_pkg::PROXY_FILTER_ENABLE_ADDR;
  wire         hit_pms      = avs_address_in == wake_proxy_pkg::PROXY_MATCH_STATUS_ADDR;
  wire         hit_mem      = (avs_address_in >= wake_proxy_pkg::WAKE_PACKET_MEMORY_ADDR) &&
                              (avs_address_in < (wake_proxy_pkg::WAKE_PACKET_MEMORY_ADDR +
                                                 wake_proxy_pkg::WAKE_PACKET_MEMORY_SPAN));
  wire [4:0]   mem_index    = avs_address_in[6:2];
  wire         mapped       = hit_wfe | hit_wms | hit_wpl | hit_pfe | hit_pms | hit_mem;
  // a write lands only at the edge where waitrequest is low, never at the edge that first sees it
  wire         wr_take      = avs_write_in & ack_reg;

  // byte lane mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
  wire [31:0]  wmask        = lane_mask(avs_byteenable_in);
  wire [31:0]  wdata_masked = avs_writedata_in & wmask;

  // read mux
  logic [31:0] read_value;
  always_comb begin
    if (hit_wfe) begin
      read_value = wake_filter_enable_reg;
    end else if (hit_wms) begin
      read_value = wake_match_status_reg;
    end else if (hit_wpl) begin
      read_value = {20'h0_0000, wake_packet_length_reg};  // R16
    end else if (hit_pfe) begin
      read_value = proxy_filter_enable_reg;
    end else if (hit_pms) begin
      read_value = proxy_match_status_reg;
    end else if (hit_mem) begin
      read_value = capture_mem_reg[mem_index];            // R18
    end else begin
      read_value = 32'h0000_0000;                         // unmapped reads zero
    end
  end

  // power-good and firmware reset from outside: three flops, second and third agree
  wire         pg_low       = ~pg_sync_reg & ~pg_last_reg;
  wire         fw_rise      = fw_sync_reg & fw_last_reg & ~fw_prev_reg;

  // offload gating
  wire         d0_offload   = proxy_filter_enable_reg[wake_proxy_pkg::OFFLOAD_D0_BIT];
  wire         offload_on   = host_proxy_enable_in & management_proxy_enable_in &     // R20
                              (device_in_d3_in | d0_offload);                          // R19 R23
  wire         flex_queuing = wake_filter_enable_reg[wake_proxy_pkg::FLEX_QUEUING_BIT];

  // per-packet criteria word, bit positions shared by wake and proxy
  wire         unicast_hit  = is_unicast_in & unicast_promiscuous_in;                  // R3 R22
  wire         directed_hit = is_unicast_in & address_hit_in & unicast_promiscuous_in; // R12
  wire         group_hit    = is_multicast_in & (hash_hit_in | multicast_promiscuous_in); // R13
  wire [31:0]  criteria = {
    8'h00,
    flex_match_in & {8{~flex_queuing}},                   // R14
    4'h0,
    arp_request_in,                                       // bit 11
    icmpv6_in & ipv6_table_hit_in,                        // R7 bit 10
    icmpv6_in,                                            // R7 bit 9
    1'b0,
    ipv6_directed_in,
    ipv4_directed_in,
    arp_request_in & ipv4_table_hit_in,                   // R6 bit 5
    is_broadcast_in,
    group_hit,
    directed_hit,
    wol_pattern_in,
    1'b0};
  // promiscuous unicast counts as a directed hit for wake and forwarding
  wire [31:0]  decide_bits  = criteria | ({31'h0, unicast_hit} << wake_proxy_pkg::DIRECTED_UCAST_BIT);

  wire         packet_good  = rx_end_in & rx_crc_good_in;                              // R24
  wire [31:0]  wake_hits    = decide_bits & wake_filter_enable_reg & wake_proxy_pkg::WAKE_STATUS_MASK; // R1 R2
  wire [31:0]  proxy_hits   = decide_bits & proxy_filter_enable_reg & wake_proxy_pkg::PROXY_STATUS_MASK; // R21
  wire         wake_packet  = packet_good & (|wake_hits);
  wire         proxy_packet = packet_good & offload_on & (|proxy_hits);
  wire         wake_frozen  = |wake_match_status_reg;                                  // R10
  wire         link_wake    = link_change_in & wake_filter_enable_reg[wake_proxy_pkg::LINK_CHANGE_BIT];
  wire         fw_wake      = fw_rise & wake_filter_enable_reg[wake_proxy_pkg::FIRMWARE_WAKE_BIT]; // R5

  // new wake status bits from this cycle's events
  wire [31:0]  wake_events  = (wake_packet ? wake_hits : 32'h0000_0000) |
                              ({31'h0, link_wake} << wake_proxy_pkg::LINK_CHANGE_BIT) |
                              ({31'h0, fw_wake} << wake_proxy_pkg::FIRMWARE_WAKE_BIT); // R15
  wire [31:0]  wake_set     = wake_frozen ? 32'h0000_0000 : wake_events;
  wire [31:0]  proxy_set    = proxy_packet ? proxy_hits : 32'h0000_0000;              // R11
  wire [31:0]  wake_clr     = (wr_take & hit_wms) ? wdata_masked : 32'h0000_0000;
  wire [31:0]  proxy_clr    = (wr_take & hit_pms) ? wdata_masked : 32'h0000_0000;
  wire         record_first = wake_packet & ~wake_frozen;                             // R10 R16
  wire [11:0]  length_sat   = (jumbo_enable_in && rx_length_in > 14'(wake_proxy_pkg::LENGTH_SATURATION)) ?
                              wake_proxy_pkg::LENGTH_SATURATION : rx_length_in[11:0]; // R17

  // status: set wins over clear; only power-good loss resets it, not pcie or core reset
  always_ff @(posedge ref_clk_in) begin
    if (pg_low) begin
      wake_match_status_reg  <= wake_proxy_pkg::STATUS_RESET_VALUE;                  // R9
      proxy_match_status_reg <= wake_proxy_pkg::STATUS_RESET_VALUE;
    end else begin
      wake_match_status_reg  <= (wake_match_status_reg & ~wake_clr) | wake_set;     // R8
      proxy_match_status_reg <= (proxy_match_status_reg & ~proxy_clr) | proxy_set;  // R8 R11
    end
  end

  // enables and bus handshake on controller reset
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      wake_filter_enable_reg  <= wake_proxy_pkg::ENABLE_RESET_VALUE;
      proxy_filter_enable_reg <= wake_proxy_pkg::ENABLE_RESET_VALUE;
      ack_reg                 <= 1'b0;
      readdata_reg            <= 32'h0000_0000;
      response_reg            <= 2'h0;
    end else begin
      ack_reg      <= access;   // answer one cycle after the request appears
      readdata_reg <= (avs_read_in & access) ? read_value : readdata_reg;
      response_reg <= access ? (mapped ? 2'h0 : 2'h2) : response_reg;
      if (wr_take && hit_wfe) begin
        wake_filter_enable_reg <= (wake_filter_enable_reg & ~wmask) |
                                  (wdata_masked & wake_proxy_pkg::WAKE_ENABLE_MASK); // R1 R2 R4
      end
      if (wr_take && hit_pfe) begin
        proxy_filter_enable_reg <= (proxy_filter_enable_reg & ~wmask) |
                                   (wdata_masked & wake_proxy_pkg::PROXY_ENABLE_MASK); // R19 R21
      end
    end
  end

  // capture of packet words; only the first wake packet is kept, no reset on the data
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || rx_end_in) begin
      capture_index_reg <= 6'h00;
    end else if (rx_data_valid_in && !wake_frozen && capture_index_reg < 6'(CAPTURE_DEPTH)) begin
      capture_mem_reg[capture_index_reg[4:0]] <= rx_data_in;                         // R18
      capture_index_reg <= capture_index_reg + 6'h01;
    end
    if (record_first) begin
      wake_packet_length_reg <= length_sat;                                          // R16 R17
    end
  end

  // synchronisers and event outputs
  always_ff @(posedge ref_clk_in) begin
    pg_meta_reg   <= aux_power_good_in;
    pg_sync_reg   <= pg_meta_reg;
    pg_last_reg   <= pg_sync_reg;
    fw_meta_reg   <= firmware_reset_in;
    fw_sync_reg   <= fw_meta_reg;
    fw_last_reg   <= fw_sync_reg;
    pcie_meta_reg <= pcie_reset_input_n_in;
    pcie_sync_reg <= pcie_meta_reg;
    if (reset_in) begin
      fw_prev_reg       <= 1'b0;
      wake_event_reg    <= 1'b0;
      proxy_forward_reg <= 1'b0;
      flex_steer_reg    <= 8'h00;
      proxy_active_reg  <= 1'b0;
    end else begin
      fw_prev_reg       <= fw_sync_reg & fw_last_reg;
      wake_event_reg    <= |wake_set;                                                // R3 R5
      proxy_forward_reg <= proxy_packet;                                             // R22
      flex_steer_reg    <= (flex_queuing && !device_in_d3_in && rx_end_in) ?        // R4
                           flex_match_in & wake_filter_enable_reg[23:16] : 8'h00;
      proxy_active_reg  <= offload_on;                                               // R20
    end
  end

  assign avs_readdata_out     = readdata_reg;
  assign avs_waitrequest_out  = ~ack_reg;
  assign avs_response_out     = response_reg;
  assign wake_event_out       = wake_event_reg;
  assign proxy_forward_out    = proxy_forward_reg;
  assign flex_queue_steer_out = flex_steer_reg;
  assign proxy_active_out     = proxy_active_reg;

endmodule // wake_proxy_filter_regs

// >>> verification/wake_proxy_filter_regs_properties.sv
// concurrent checks on the bus handshake and event outputs of the filter register block
`timescale 1ns/1ps
module wake_proxy_filter_regs_checker (
  input wire logic        ref_clk_in,
  input wire logic        reset_in,
  input wire logic [15:0] avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [1:0]  avs_response_out,
  input wire logic        rx_end_in,
  input wire logic        rx_crc_good_in,
  input wire logic [7:0]  flex_match_in,
  input wire logic        link_change_in,
  input wire logic        firmware_reset_in,
  input wire logic        host_proxy_enable_in,
  input wire logic        management_proxy_enable_in,
  input wire logic        wake_event_out,
  input wire logic        proxy_forward_out,
  input wire logic [7:0]  flex_queue_steer_out
);
  // address decode, so mapped and unmapped answers can be told apart
  wire logic mapped;
  assign mapped = (avs_address_in inside {wake_proxy_pkg::WAKE_FILTER_ENABLE_ADDR, wake_proxy_pkg::WAKE_MATCH_STATUS_ADDR,
    wake_proxy_pkg::WAKE_PACKET_LENGTH_ADDR, wake_proxy_pkg::PROXY_FILTER_ENABLE_ADDR,
    wake_proxy_pkg::PROXY_MATCH_STATUS_ADDR}) || (avs_address_in >= wake_proxy_pkg::WAKE_PACKET_MEMORY_ADDR &&
    avs_address_in < wake_proxy_pkg::WAKE_PACKET_MEMORY_ADDR + wake_proxy_pkg::WAKE_PACKET_MEMORY_SPAN);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);
  property p_ack;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered in one cycle");
  property p_ack_pulse;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("waitrequest low for more than one cycle");
  property p_ok_resp;
    avs_read_in && !avs_waitrequest_out && mapped |-> avs_response_out == 2'b00;
  endproperty
  a_ok_resp: assert property (p_ok_resp) else $error("mapped read answered with error");
  property p_unmapped;
    avs_read_in && !avs_waitrequest_out && !mapped |-> avs_response_out == 2'b10 && avs_readdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_hold;
    !avs_read_in && !avs_write_in && avs_waitrequest_out |=> $stable(avs_readdata_out);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without access");
  property p_bad_crc;
    rx_end_in && !rx_crc_good_in && !link_change_in && !firmware_reset_in |=> !wake_event_out && !proxy_forward_out;
  endproperty
  a_bad_crc: assert property (p_bad_crc) else $error("event from bad frame");
  property p_forward;
    proxy_forward_out |-> $past(rx_end_in && rx_crc_good_in && host_proxy_enable_in && management_proxy_enable_in);
  endproperty
  a_forward: assert property (p_forward) else $error("forward without good frame and both enables");
  property p_steer;
    flex_queue_steer_out != 8'h00 |-> ($past(flex_match_in) & flex_queue_steer_out) == flex_queue_steer_out;
  endproperty
  a_steer: assert property (p_steer) else $error("queue steer without flex hit");
  c_wake: cover property (wake_event_out);
  c_forward: cover property (proxy_forward_out);
  c_refused: cover property (avs_response_out == 2'b10 && !avs_waitrequest_out);
endmodule // wake_proxy_filter_regs_checker

// >>> verification/test_wake_proxy_filter_regs.sv
// self-checking testbench for the wake and proxy filter register block
`timescale 1ns/1ps
module test_wake_proxy_filter_regs;
  typedef struct {
    logic [31:0] en;   // wake enable word
    logic [11:0] pk;   // packet decision flags
    logic [7:0]  fx;   // flex hits
    logic [1:0]  prom; // {multicast, unicast} promiscuous
    logic        crc;  // good frame check
    logic [31:0] exp;  // expected wake status
  } row_s;
  localparam logic [31:0] all_en = 32'h00ff_0efe;
  localparam logic [15:0] we = wake_proxy_pkg::WAKE_FILTER_ENABLE_ADDR;
  localparam logic [15:0] ws = wake_proxy_pkg::WAKE_MATCH_STATUS_ADDR;
  localparam logic [15:0] pe = wake_proxy_pkg::PROXY_FILTER_ENABLE_ADDR;
  localparam logic [15:0] ps = wake_proxy_pkg::PROXY_MATCH_STATUS_ADDR;
  // ordinary packet cases, one per source and mode
  row_s rows [16] = '{'{all_en, 12'h001, 8'h0, 2'b01, 1, 32'h4}, '{all_en, 12'h00c, 8'h0, 2'b00, 1, 32'h8},
    '{all_en, 12'h004, 8'h0, 2'b10, 1, 32'h8}, '{all_en, 12'h004, 8'h0, 2'b00, 1, 32'h0},
    '{all_en, 12'h010, 8'h0, 2'b00, 1, 32'h10}, '{all_en, 12'h0c0, 8'h0, 2'b00, 1, 32'h820},
    '{all_en, 12'h040, 8'h0, 2'b00, 1, 32'h800}, '{all_en, 12'hc00, 8'h0, 2'b00, 1, 32'h600},
    '{all_en, 12'h400, 8'h0, 2'b00, 1, 32'h200}, '{all_en, 12'h020, 8'h0, 2'b00, 1, 32'h2},
    '{all_en, 12'h300, 8'h0, 2'b00, 1, 32'hc0}, '{all_en, 12'h000, 8'h81, 2'b00, 1, 32'h81_0000},
    '{32'h007f_0000, 12'h000, 8'h81, 2'b00, 1, 32'h1_0000}, '{32'h00ff_4000, 12'h000, 8'h81, 2'b00, 1, 32'h0},
    '{all_en, 12'h010, 8'h0, 2'b00, 0, 32'h0}, '{32'h0000_0010, 12'h020, 8'h0, 2'b00, 1, 32'h0}};
  logic        ref_clk_in = 0, reset_in = 1, pcie_n = 1, pgood = 0, rd = 0, wr = 0, wait_o, dv = 0, rx_end = 0;
  logic        crc = 0, jumbo = 0, upe = 0, mpe = 0, link = 0, fwr = 0, hpe = 1, mgpe = 1, d3 = 0;
  logic        wake_ev, fwd, active;
  logic [9:0]  ev;   // {steer, forward, wake} seen one cycle after the packet end
  logic [15:0] addr = 16'h0;
  logic [31:0] wdata = 32'h0, rdata, dat = 32'h0, seen;
  logic [3:0]  be = 4'hf;
  logic [1:0]  resp, seen_resp;
  logic [13:0] len = 14'h0;
  logic [11:0] pf = 12'h0;
  logic [7:0]  fx = 8'h0, steer;
  int          bad_count = 0, check_count = 0;
  wake_proxy_filter_regs wake_proxy_filter_regs_inst (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .pcie_reset_input_n_in(pcie_n), .aux_power_good_in(pgood),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o), .avs_response_out(resp),
    .rx_data_valid_in(dv), .rx_data_in(dat), .rx_end_in(rx_end), .rx_crc_good_in(crc), .rx_length_in(len),
    .jumbo_enable_in(jumbo), .unicast_promiscuous_in(upe), .multicast_promiscuous_in(mpe),
    .is_unicast_in(pf[0]), .address_hit_in(pf[1]), .is_multicast_in(pf[2]), .hash_hit_in(pf[3]),
    .is_broadcast_in(pf[4]), .wol_pattern_in(pf[5]), .arp_request_in(pf[6]), .ipv4_table_hit_in(pf[7]),
    .ipv4_directed_in(pf[8]), .ipv6_directed_in(pf[9]), .icmpv6_in(pf[10]), .ipv6_table_hit_in(pf[11]),
    .flex_match_in(fx), .link_change_in(link), .firmware_reset_in(fwr), .host_proxy_enable_in(hpe),
    .management_proxy_enable_in(mgpe), .device_in_d3_in(d3), .wake_event_out(wake_ev),
    .proxy_forward_out(fwd), .flex_queue_steer_out(steer), .proxy_active_out(active));
  // free-running 250 MHz clock
  always #2 ref_clk_in = ~ref_clk_in;
  task final_report;
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // one avalon access; held until waitrequest is sampled low, released one edge before the next
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wait_o !== 1'b0 && n < 40);
    if (n >= 40) cmp("bus_timeout", 32'h0, 32'h1);
    seen = rdata;
    seen_resp = resp;
    rd <= 0;
    wr <= 0;
    @(posedge ref_clk_in);
  endtask
  task chk(input string n, input logic [15:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    cmp(n, e, seen);
  endtask
  // status is write-one-to-clear, so all ones empties both words
  task clr;
    bus(1, ws, 32'hffff_ffff);
    bus(1, ps, 32'hffff_ffff);
  endtask
  // optional data words, then the end-of-packet decision
  task pkt(input logic [11:0] p, input logic [7:0] f, input logic c, input int nw, input logic [13:0] l);
    for (int i = 0; i < nw; i++) begin
      dv <= 1;
      dat <= 32'hc0de_0000 | 32'(i);
      @(posedge ref_clk_in);
    end
    dv <= 0;
    pf <= p;
    fx <= f;
    crc <= c;
    len <= l;
    rx_end <= 1;
    @(posedge ref_clk_in);
    rx_end <= 0;
    pf <= 12'h0;
    fx <= 8'h0;
    @(posedge ref_clk_in);
    ev = {steer, fwd, wake_ev};
    @(posedge ref_clk_in);
  endtask
  // main sequence: reset, table of packets, then the awkward cases
  initial begin
    repeat (8) @(posedge ref_clk_in);
    reset_in <= 0;
    pgood <= 1;
    chk("wake_en_reset", we, 32'h0);
    chk("wake_status_init", ws, 32'h0);
    bus(1, we, 32'hffff_ffff);
    chk("wake_en_bits", we, 32'h8fff_ceff);
    bus(1, pe, 32'hffff_ffff);
    chk("proxy_en_bits", pe, 32'h00ff_0efd);
    foreach (rows[i]) begin
      clr();
      bus(1, we, rows[i].en);
      bus(1, pe, (rows[i].en & 32'h00ff_0efc) | 32'h1);
      {mpe, upe} <= rows[i].prom;
      pkt(rows[i].pk, rows[i].fx, rows[i].crc, 0, 14'd64);
      chk("wake_status", ws, rows[i].exp);
      chk("proxy_status", ps, rows[i].exp & 32'h00ff_0efc);
      cmp("events", {22'h0, (rows[i].en[14] ? rows[i].fx & rows[i].en[23:16] : 8'h00),
        |(rows[i].exp & 32'h00ff_0efc), |rows[i].exp}, {22'h0, ev});
    end
    clr();
    bus(1, we, all_en);
    bus(1, pe, all_en | 32'h1);
    pkt(12'h010, 8'h0, 1, 0, 14'd64);
    pkt(12'h040, 8'h0, 1, 0, 14'd64);
    chk("wake_frozen", ws, 32'h10);
    chk("proxy_accum", ps, 32'h810);
    be <= 4'b0001;
    bus(1, ps, 32'hffff_ffff);
    be <= 4'hf;
    chk("proxy_lane_clear", ps, 32'h800);
    pcie_n <= 0;
    reset_in <= 1;
    repeat (8) @(posedge ref_clk_in);
    reset_in <= 0;
    pcie_n <= 1;
    chk("status_kept", ws, 32'h10);
    pgood <= 0;
    repeat (8) @(posedge ref_clk_in);
    pgood <= 1;
    chk("status_power_clear", ws, 32'h0);
    bus(1, we, all_en);
    jumbo <= 1;
    pkt(12'h010, 8'h0, 1, 40, 14'd3000);
    chk("length_saturated", wake_proxy_pkg::WAKE_PACKET_LENGTH_ADDR, 32'h7ff);
    chk("memory_first", wake_proxy_pkg::WAKE_PACKET_MEMORY_ADDR, 32'hc0de_0000);
    chk("memory_last", wake_proxy_pkg::WAKE_PACKET_MEMORY_ADDR + 16'h7c, 32'hc0de_001f);
    chk("unmapped_data", 16'h5804, 32'h0);
    cmp("unmapped_resp", 32'h2, {30'h0, seen_resp});
    clr();
    bus(1, we, 32'h8000_0001);
    link <= 1;
    @(posedge ref_clk_in);
    link <= 0;
    repeat (3) @(posedge ref_clk_in);
    chk("link_wake", ws, 32'h1);
    clr();
    fwr <= 1;
    repeat (8) @(posedge ref_clk_in);
    chk("firmware_wake", ws, 32'h8000_0000);
    fwr <= 0;
    bus(1, pe, 32'h0);
    repeat (4) @(posedge ref_clk_in);
    cmp("active_d0", 32'h0, {31'h0, active});
    d3 <= 1;
    repeat (4) @(posedge ref_clk_in);
    cmp("active_d3", 32'h1, {31'h0, active});
    hpe <= 0;
    repeat (4) @(posedge ref_clk_in);
    cmp("active_host_off", 32'h0, {31'h0, active});
    final_report();
  end
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    bad_count++;
    final_report();
  end
endmodule // test_wake_proxy_filter_regs
bind wake_proxy_filter_regs wake_proxy_filter_regs_checker checker_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .avs_response_out(avs_response_out),
  .rx_end_in(rx_end_in), .rx_crc_good_in(rx_crc_good_in), .flex_match_in(flex_match_in),
  .link_change_in(link_change_in), .firmware_reset_in(firmware_reset_in), .host_proxy_enable_in(host_proxy_enable_in),
  .management_proxy_enable_in(management_proxy_enable_in), .wake_event_out(wake_event_out),
  .proxy_forward_out(proxy_forward_out), .flex_queue_steer_out(flex_queue_steer_out));
